//--- verilog/ocd_pkg.sv
// Package of shared constants for the output clock distribution block.
package ocd_pkg;
    // ------------------------------------------------------------------
    // Sizes of the distribution
    // ------------------------------------------------------------------
    localparam int OCD_NUM_SRC = 6;
    localparam int OCD_NUM_DIV = 11;
    localparam int OCD_NUM_OUT = 16;
    localparam int OCD_NUM_CMOS = 4;
    localparam int OCD_NUM_GPIO = 2;
    localparam int OCD_CD_W = 12;
    localparam int OCD_SD_W = 20;
    localparam int OCD_DLY_W = 8;
    localparam int OCD_SR_TAPS = 8;
    localparam int OCD_SR_TAP_W = 3;
    // ------------------------------------------------------------------
    // Source indices of the six-way multiplexer
    // ------------------------------------------------------------------
    localparam logic [2:0] OCD_SRC_LOOP3 = 3'h0;
    localparam logic [2:0] OCD_SRC_LOOP2 = 3'h1;
    localparam logic [2:0] OCD_SRC_LOOP1_PRI = 3'h2;
    localparam logic [2:0] OCD_SRC_LOOP1_SEC = 3'h3;
    localparam logic [2:0] OCD_SRC_XO = 3'h4;
    localparam logic [2:0] OCD_SRC_REF = 3'h5;
    // ------------------------------------------------------------------
    // Request configuration register and its fields
    // ------------------------------------------------------------------
    localparam logic [7:0] OCD_SYSREF_REQUEST_CONFIG_OFS = 8'h1a;
    localparam int OCD_REQ_MODE_LSB = 4;
    localparam int OCD_REQ_SEL_LSB = 2;
    localparam logic [1:0] OCD_REQ_MODE_RESAMPLE = 2'h3;
    // ------------------------------------------------------------------
    // Single-ended driver modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OCD_CMOS_NORMAL = 2'h0,
        OCD_CMOS_INVERT = 2'h1,
        OCD_CMOS_HIZ = 2'h2,
        OCD_CMOS_LOW = 2'h3
    } ocd_cmos_mode_t;
    // ------------------------------------------------------------------
    // Zero-delay feedback tap selection
    // ------------------------------------------------------------------
    localparam logic [1:0] OCD_ZDF_NONE = 2'h0;
    localparam logic [1:0] OCD_ZDF_CH0 = 2'h1;
    localparam logic [1:0] OCD_ZDF_CH4 = 2'h2;
    localparam logic [1:0] OCD_ZDF_CH10 = 2'h3;
    // Divider indices used by the request sampler.
    localparam int OCD_DIV_CH0 = 0;
    localparam int OCD_DIV_CH1 = 1;
    localparam int OCD_DIV_CH45 = 4;
    localparam int OCD_DIV_CH1011 = 7;
endpackage

//--- verilog/ocd_div_if.sv
// Interface joining the distribution top to one divider core.
`timescale 1ns/1ns
interface ocd_div_if #(parameter int W = 12);
    logic enable;
    logic hold;
    logic tick;
    logic src_lvl;
    logic [W-1:0] ratio;
    logic [7:0] delay;
    logic out;
    logic out_tick;
    modport core (input enable, input hold, input tick, input src_lvl, input ratio, input delay,
                  output out, output out_tick);
    modport ctrl (output enable, output hold, output tick, output src_lvl, output ratio, output delay,
                  input out, input out_tick);
endinterface

//--- verilog/ocd_div_core.sv
// Integer divider core with static start delay, sync hold and bypass.
`timescale 1ns/1ns
module ocd_div_core
    import ocd_pkg::*;
#(
    parameter int W = 12
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    ocd_div_if.core div
);
    logic [W-1:0] cnt_reg;
    logic [7:0] dly_reg;
    logic out_reg;
    logic out_tick_reg;
    logic bypass;
    logic [W-1:0] last_cnt;
    logic [W-1:0] high_cnt;

    // A ratio of zero is treated as one, so every code gives a legal divider.
    assign bypass = (div.ratio <= W'(1));
    assign last_cnt = div.ratio - W'(1);
    // One bit wider, so the top ratio does not wrap to a zero high phase.
    assign high_cnt = W'(({1'b0, div.ratio} + (W+1)'(1)) >> 1);

    // ------------------------------------------------------------------
    // Counter and output level
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || !div.enable) begin
            cnt_reg <= '0;
            dly_reg <= 8'h00;
            out_reg <= 1'b0;
        end else if (bypass) begin
            out_reg <= div.src_lvl;
            cnt_reg <= '0;
            dly_reg <= div.delay;
        end else if (div.hold) begin
            cnt_reg <= '0;
            dly_reg <= div.delay;
            out_reg <= 1'b0;
        end else if (div.tick) begin
            if (dly_reg != 8'h00) begin
                dly_reg <= dly_reg - 8'h01;
            end else begin
                // One output period for every ratio source edges.
                out_reg <= (cnt_reg < high_cnt);
                cnt_reg <= (cnt_reg >= last_cnt) ? '0 : cnt_reg + W'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // Rising-edge strobe for a cascaded stage
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in || !div.enable) begin
            out_tick_reg <= 1'b0;
        end else if (bypass) begin
            out_tick_reg <= div.tick;
        end else begin
            out_tick_reg <= div.tick && !div.hold && (dly_reg == 8'h00) && (cnt_reg == '0);
        end
    end

    assign div.out = out_reg;
    assign div.out_tick = out_tick_reg;
endmodule // ocd_div_core

//--- verilog/ocd_distribution.sv
// Output clock distribution: source muxes, dividers, delays, drivers and taps.
`timescale 1ns/1ns
module ocd_distribution
    import ocd_pkg::*;
#(
    parameter int CD_W = OCD_CD_W,
    parameter int SD_W = OCD_SD_W
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [OCD_NUM_SRC-1:0] src_clk_in,
    input wire logic [2:0] ch0_sel_in,
    input wire logic [2:0] ch1_sel_in,
    input wire logic [1:0] ch23_sel_in,
    input wire logic bank47_sel_in,
    input wire logic bank813_sel_in,
    input wire logic ch1415_sel_in,
    input wire logic [OCD_NUM_DIV*CD_W-1:0] cd_ratio_in,
    input wire logic [OCD_NUM_DIV*OCD_DLY_W-1:0] cd_delay_in,
    input wire logic [OCD_NUM_DIV*SD_W-1:0] sd_ratio_in,
    input wire logic [OCD_NUM_DIV*OCD_DLY_W-1:0] sd_delay_in,
    input wire logic [OCD_NUM_DIV*OCD_SR_TAP_W-1:0] sd_dig_delay_in,
    input wire logic [OCD_NUM_DIV-1:0] sd_enable_in,
    input wire logic [OCD_NUM_DIV-1:0] sd_pulse_mode_in,
    input wire logic [OCD_NUM_DIV-1:0] div_sync_en_in,
    input wire logic [OCD_NUM_DIV-1:0] sd_sync_en_in,
    input wire logic [OCD_NUM_OUT-1:0] drv_en_in,
    input wire logic sync_pin_in,
    input wire logic sync_sw_in,
    input wire logic [OCD_NUM_DIV-1:0] replica_source_enable_in,
    input wire logic [OCD_NUM_GPIO-1:0] pin_output_enable_in,
    input wire logic [1:0] request_resample_mode_in,
    input wire logic [1:0] request_sample_source_in,
    input wire logic sysref_req_in,
    input wire logic [2*OCD_NUM_CMOS-1:0] cmos_mode_in,
    input wire logic [1:0] zero_delay_feedback_sel_in,
    output logic [OCD_NUM_OUT-1:0] clk_out,
    output logic [OCD_NUM_CMOS-1:0] cmos_out,
    output logic [OCD_NUM_CMOS-1:0] cmos_oe_out,
    output logic [OCD_NUM_GPIO-1:0] gpio_replica_out,
    output logic [OCD_NUM_GPIO-1:0] gpio_replica_oe_out,
    output logic zero_delay_feedback_out,
    output logic sysref_req_sampled_out,
    output logic [OCD_NUM_DIV-1:0] div_active_out
);
    // ------------------------------------------------------------------
    // Divider topology helpers
    // ------------------------------------------------------------------
    function automatic logic has_sd(input int idx);
        return !(idx == 2 || idx == 3);
    endfunction

    // Output pin to divider index.
    function automatic int out_div(input int c);
        if (c < 4) begin
            return c;
        end else if (c < 14) begin
            return 4 + (c - 4) / 2;
        end
        return c - 5;
    endfunction

    // Source picked for each divider by its bank mux.
    function automatic logic [2:0] div_src(input int idx);
        if (idx == 0) begin
            return ch0_sel_in;
        end else if (idx == 1) begin
            return ch1_sel_in;
        end else if (idx <= 3) begin
            return (ch23_sel_in > 2'h2) ? OCD_SRC_LOOP1_PRI : {1'b0, ch23_sel_in};
        end else if (idx <= 5) begin
            return bank47_sel_in ? OCD_SRC_LOOP2 : OCD_SRC_LOOP3;
        end else if (idx <= 8) begin
            return bank813_sel_in ? OCD_SRC_LOOP2 : OCD_SRC_LOOP3;
        end
        return ch1415_sel_in ? OCD_SRC_LOOP1_PRI : OCD_SRC_LOOP2;
    endfunction

    // Divider power follows its drivers.
    function automatic logic div_powered(input int idx);
        if (idx <= 1) begin
            return drv_en_in[idx];
        end else if (idx <= 3) begin
            return drv_en_in[2] | drv_en_in[3];
        end else if (idx <= 8) begin
            return drv_en_in[2*idx-4] | drv_en_in[2*idx-3];
        end
        return drv_en_in[14] | drv_en_in[15];
    endfunction

    // ------------------------------------------------------------------
    // Source edge detection
    // ------------------------------------------------------------------
    logic [OCD_NUM_SRC-1:0] src_lvl_reg;
    logic [OCD_NUM_SRC-1:0] src_prev_reg;
    logic [OCD_NUM_SRC-1:0] src_tick;
    logic sync_active;
    logic [OCD_NUM_DIV-1:0] cd_tick;
    logic [OCD_NUM_DIV-1:0] chan_lvl;
    logic [OCD_NUM_DIV-1:0] rep_lvl;
    logic req_s1_reg;
    logic req_s2_reg;
    logic req_gate_reg;

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            src_lvl_reg <= '0;
            src_prev_reg <= '0;
        end else begin
            src_lvl_reg <= src_clk_in;
            src_prev_reg <= src_lvl_reg;
        end
    end

    assign src_tick = src_lvl_reg & ~src_prev_reg;
    assign sync_active = sync_pin_in | sync_sw_in;

    // ------------------------------------------------------------------
    // Divider chains
    // ------------------------------------------------------------------
    for (genvar i = 0; i < OCD_NUM_DIV; i++) begin : g_div
        ocd_div_if #(.W(CD_W)) cd_if ();
        logic [2:0] sel;

        // The mux is re-read every cycle, so a new source is followed at once.
        // Procedural, so that the ports read inside the functions wake the logic.
        always_comb sel = div_src(i);
        always_comb cd_if.enable = div_powered(i);
        assign cd_if.hold = sync_active & div_sync_en_in[i];
        assign cd_if.tick = (sel < 3'(OCD_NUM_SRC)) ? src_tick[sel] : 1'b0;
        assign cd_if.src_lvl = (sel < 3'(OCD_NUM_SRC)) ? src_lvl_reg[sel] : 1'b0;
        assign cd_if.ratio = cd_ratio_in[i*CD_W +: CD_W];
        assign cd_if.delay = cd_delay_in[i*OCD_DLY_W +: OCD_DLY_W];
        assign cd_tick[i] = cd_if.out_tick;

        ocd_div_core #(.W(CD_W)) u_cd (
            .ref_clk_in(ref_clk_in),
            .rst_n_in(rst_n_in),
            .div(cd_if.core)
        );

        if (has_sd(i)) begin : g_sd
            ocd_div_if #(.W(SD_W)) sd_if ();
            logic [OCD_SR_TAPS-1:0] dig_sh_reg;
            logic sd_dly;

            // Cascade counts channel periods, so total ratio is the product.
            assign sd_if.enable = cd_if.enable & sd_enable_in[i];
            assign sd_if.hold = cd_if.hold & sd_sync_en_in[i];
            assign sd_if.tick = cd_if.out_tick;
            assign sd_if.src_lvl = cd_if.out;
            assign sd_if.ratio = sd_ratio_in[i*SD_W +: SD_W];
            assign sd_if.delay = sd_delay_in[i*OCD_DLY_W +: OCD_DLY_W];

            ocd_div_core #(.W(SD_W)) u_sd (
                .ref_clk_in(ref_clk_in),
                .rst_n_in(rst_n_in),
                .div(sd_if.core)
            );

            // Digital delay in channel periods, applied after the replica tap.
            always_ff @(posedge ref_clk_in) begin
                if (!rst_n_in || !sd_if.enable) begin
                    dig_sh_reg <= '0;
                end else if (cd_if.out_tick) begin
                    dig_sh_reg <= {dig_sh_reg[OCD_SR_TAPS-2:0], sd_if.out};
                end
            end

            assign sd_dly = (sd_dig_delay_in[i*OCD_SR_TAP_W +: OCD_SR_TAP_W] == '0) ? sd_if.out :
                dig_sh_reg[sd_dig_delay_in[i*OCD_SR_TAP_W +: OCD_SR_TAP_W] - OCD_SR_TAP_W'(1)];
            assign rep_lvl[i] = sd_if.enable & sd_if.out;
            assign chan_lvl[i] = !sd_enable_in[i] ? cd_if.out :
                (sd_pulse_mode_in[i] ? (sd_dly & req_gate_reg) : sd_dly);
        end else begin : g_no_sd
            assign rep_lvl[i] = 1'b0;
            assign chan_lvl[i] = cd_if.out;
        end
    end

    // ------------------------------------------------------------------
    // Request sampling
    // ------------------------------------------------------------------
    // Resample mode aligns the request to the chosen divider's edges; this
    // costs up to one divider period of latency but makes outputs coherent.
    logic req_src_tick;

    always_comb begin
        unique case (request_sample_source_in)
            2'h0: req_src_tick = cd_tick[OCD_DIV_CH0];
            2'h1: req_src_tick = cd_tick[OCD_DIV_CH1];
            2'h2: req_src_tick = cd_tick[OCD_DIV_CH45];
            2'h3: req_src_tick = cd_tick[OCD_DIV_CH1011];
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
        end else begin
            req_s1_reg <= sysref_req_in;
            req_s2_reg <= req_s1_reg;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            req_gate_reg <= 1'b0;
        end else if (request_resample_mode_in == OCD_REQ_MODE_RESAMPLE) begin
            if (req_src_tick) begin
                req_gate_reg <= req_s2_reg;
            end
        end else begin
            req_gate_reg <= req_s1_reg;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            sysref_req_sampled_out <= 1'b0;
        end else begin
            sysref_req_sampled_out <= req_gate_reg;
        end
    end

    // ------------------------------------------------------------------
    // Output drivers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            clk_out <= '0;
        end else begin
            for (int c = 0; c < OCD_NUM_OUT; c++) begin
                clk_out[c] <= drv_en_in[c] & chan_lvl[out_div(c)];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            div_active_out <= '0;
        end else begin
            for (int d = 0; d < OCD_NUM_DIV; d++) begin
                div_active_out[d] <= div_powered(d);
            end
        end
    end

    // Single-ended pair drivers of channels zero and one.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            cmos_out <= '0;
            cmos_oe_out <= '0;
        end else begin
            for (int k = 0; k < OCD_NUM_CMOS; k++) begin
                unique case (ocd_cmos_mode_t'(cmos_mode_in[2*k +: 2]))
                    OCD_CMOS_NORMAL: begin
                        cmos_out[k] <= drv_en_in[k/2] & chan_lvl[k/2];
                        cmos_oe_out[k] <= drv_en_in[k/2];
                    end
                    OCD_CMOS_INVERT: begin
                        cmos_out[k] <= drv_en_in[k/2] & ~chan_lvl[k/2];
                        cmos_oe_out[k] <= drv_en_in[k/2];
                    end
                    OCD_CMOS_HIZ: begin
                        cmos_out[k] <= 1'b0;
                        cmos_oe_out[k] <= 1'b0;
                    end
                    OCD_CMOS_LOW: begin
                        cmos_out[k] <= 1'b0;
                        cmos_oe_out[k] <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Replica pins and zero-delay feedback tap
    // ------------------------------------------------------------------
    // Sources are OR-ed; with more than one enabled the replica is corrupt,
    // which is why software must enable exactly one.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            gpio_replica_out <= '0;
            gpio_replica_oe_out <= '0;
        end else begin
            for (int g = 0; g < OCD_NUM_GPIO; g++) begin
                gpio_replica_out[g] <= pin_output_enable_in[g] & |(rep_lvl & replica_source_enable_in);
                gpio_replica_oe_out[g] <= pin_output_enable_in[g];
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            zero_delay_feedback_out <= 1'b0;
        end else begin
            unique case (zero_delay_feedback_sel_in)
                OCD_ZDF_NONE: zero_delay_feedback_out <= 1'b0;
                OCD_ZDF_CH0: zero_delay_feedback_out <= chan_lvl[out_div(0)];
                OCD_ZDF_CH4: zero_delay_feedback_out <= chan_lvl[out_div(4)];
                OCD_ZDF_CH10: zero_delay_feedback_out <= chan_lvl[out_div(10)];
            endcase
        end
    end
endmodule // ocd_distribution

//--- test/ocd_dist_props.sv
// Concurrent checks on the ports of the output clock distribution.
`timescale 1ns/1ns
module ocd_dist_props
    import ocd_pkg::*;
#(
    parameter int CD_W = OCD_CD_W
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [OCD_NUM_DIV*CD_W-1:0] cd_ratio_in,
    input wire logic [OCD_NUM_DIV-1:0] div_sync_en_in,
    input wire logic [OCD_NUM_DIV-1:0] sd_enable_in,
    input wire logic [OCD_NUM_OUT-1:0] drv_en_in,
    input wire logic sync_pin_in,
    input wire logic sync_sw_in,
    input wire logic [OCD_NUM_GPIO-1:0] pin_output_enable_in,
    input wire logic [2*OCD_NUM_CMOS-1:0] cmos_mode_in,
    input wire logic [1:0] zero_delay_feedback_sel_in,
    input wire logic [OCD_NUM_OUT-1:0] clk_out,
    input wire logic [OCD_NUM_CMOS-1:0] cmos_out,
    input wire logic [OCD_NUM_CMOS-1:0] cmos_oe_out,
    input wire logic [OCD_NUM_GPIO-1:0] gpio_replica_oe_out,
    input wire logic zero_delay_feedback_out,
    input wire logic [OCD_NUM_DIV-1:0] div_active_out
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Four cycles of hold let any bypass level already in the pipeline drain first.
    sequence s_hold0;
        ((sync_pin_in || sync_sw_in) && div_sync_en_in[0] && !sd_enable_in[0] && cd_ratio_in[CD_W-1:0] > 1) [*4];
    endsequence
    sequence s_inv_pair;
        (drv_en_in[0] && cmos_mode_in[3:0] == 4'h4) [*3];
    endsequence
    AST_SYNC_HOLD: assert property (s_hold0 |-> !clk_out[0]) else $error("held divider output not low");
    AST_PWR_CH0: assert property (!drv_en_in[0] [*2] |-> !div_active_out[0]) else $error("ch0 divider on");
    AST_PWR_CH1: assert property (drv_en_in[1] [*2] |-> div_active_out[1]) else $error("ch1 divider off");
    AST_PAIR_OFF: assert property (drv_en_in[9:8] == 2'h0 [*2] |-> !div_active_out[6]) else $error("pair on");
    AST_PAIR_ON: assert property ((|drv_en_in[5:4]) [*2] |-> div_active_out[4]) else $error("pair off");
    AST_CMOS_HIZ: assert property (cmos_mode_in[1:0] == 2'h2 [*2] |-> !cmos_oe_out[0]) else $error("hiz drives");
    AST_CMOS_LOW: assert property (cmos_mode_in[1:0] == 2'h3 [*2] |-> cmos_oe_out[0] && !cmos_out[0])
        else $error("static low wrong");
    AST_CMOS_INV: assert property (s_inv_pair |-> cmos_out[1] != cmos_out[0]) else $error("polarity");
    AST_REPLICA_OE: assert property (!pin_output_enable_in[0] [*2] |-> !gpio_replica_oe_out[0])
        else $error("replica pin driven while disabled");
    AST_ZDF_NONE: assert property (zero_delay_feedback_sel_in == 2'h0 [*2] |-> !zero_delay_feedback_out)
        else $error("feedback tap active with none chosen");
endmodule // ocd_dist_props

bind ocd_distribution ocd_dist_props #(.CD_W(CD_W)) ocd_dist_props_i (.*);

//--- test/ocd_rx_model.sv
// Downstream clock receiver that times the period of the line it watches.
`timescale 1ns/1ns
module ocd_rx_model (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic line_in,
    output int edge_cnt_out,
    output int period_out
);
    logic last_reg;
    int span_reg;
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            last_reg <= 1'b0;
            span_reg <= 0;
            edge_cnt_out <= 0;
            period_out <= 0;
        end else begin
            last_reg <= line_in;
            span_reg <= (line_in && !last_reg) ? 1 : span_reg + 1;
            if (line_in && !last_reg) begin
                edge_cnt_out <= edge_cnt_out + 1;
                period_out <= span_reg;
            end
        end
    end
endmodule // ocd_rx_model

//--- test/tb.sv
// Self-checking bench of the output clock distribution.
`timescale 1ns/1ns
module tb
    import ocd_pkg::*;
;
    logic ref_clk_in = 0;
    logic rst_n_in = 0;
    logic [5:0] src_clk_in = '0;
    logic [2:0] ch0_sel_in = '0, ch1_sel_in = '0;
    logic [1:0] ch23_sel_in = '0, request_resample_mode_in = '0, request_sample_source_in = '0;
    logic [1:0] zero_delay_feedback_sel_in = '0, pin_output_enable_in = '0;
    logic bank47_sel_in = 0, bank813_sel_in = 0, ch1415_sel_in = 0, sync_pin_in = 0, sync_sw_in = 0, sysref_req_in = 0;
    logic [131:0] cd_ratio_in = '0;
    logic [87:0] cd_delay_in = '0, sd_delay_in = '0;
    logic [219:0] sd_ratio_in = '0;
    logic [32:0] sd_dig_delay_in = '0;
    logic [10:0] sd_enable_in = '0, sd_pulse_mode_in = '0, div_sync_en_in = '0, sd_sync_en_in = '0;
    logic [10:0] replica_source_enable_in = '0, div_active_out;
    logic [15:0] drv_en_in = '1, clk_out;
    logic [7:0] cmos_mode_in = 8'h04;
    logic [3:0] cmos_out, cmos_oe_out;
    logic [1:0] gpio_replica_out, gpio_replica_oe_out;
    logic zero_delay_feedback_out, sysref_req_sampled_out, watch;
    int probe_sel = 0, rx_edges, rx_period, error_cnt = 0, checks = 0;
    int hp[6] = '{2, 3, 4, 5, 6, 7};
    int ph[6] = '{0, 0, 0, 0, 0, 0};
    int dv[5] = '{0, 1, 2, 4, 6};
    int ck[5] = '{0, 1, 2, 4, 8};
    logic [18:0] probe_bus;
    assign probe_bus = {zero_delay_feedback_out, gpio_replica_out, clk_out};
    assign watch = probe_bus[probe_sel];
    ocd_distribution ocd_distribution_i (.*);
    ocd_rx_model ocd_rx_model_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .line_in(watch),
                                 .edge_cnt_out(rx_edges), .period_out(rx_period));
    initial forever #10 ref_clk_in = !ref_clk_in;
    // Each source toggles every hp cycles, so its period is twice that.
    always @(negedge ref_clk_in) begin
        for (int k = 0; k < 6; k++) begin
            ph[k] = (ph[k] + 1) % hp[k];
            if (ph[k] == 0) src_clk_in[k] = !src_clk_in[k];
        end
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic conclude();
        if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic set_cd(input int i, input int n);
        cd_ratio_in[i*12 +: 12] = n[11:0];
    endtask
    // The first edges after a change may be a stray or short period, so the fourth is timed.
    task automatic measure(input int sel, input int exp);
        int n0;
        int k;
        probe_sel = sel;
        n0 = rx_edges;
        for (k = 0; k < 4000 && rx_edges < n0 + 4; k++) @(negedge ref_clk_in);
        if (k == 4000) begin
            cmp("edge wait", 1, 0);
            conclude();
        end else begin
            cmp($sformatf("period of probe %0d", sel), exp, rx_period);
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        int n0;
        int r[5];
        int sr[5];
        logic [15:0] d;
        void'($urandom(63));
        repeat (16) @(negedge ref_clk_in);
        cmp("reset clk", 0, clk_out);
        rst_n_in = 1;
        for (int s = 0; s < 6; s++) begin
            sr = '{s, 5 - s, s % 3, s % 2, s % 2};
            ch0_sel_in = 3'(sr[0]);
            ch1_sel_in = 3'(sr[1]);
            ch23_sel_in = 2'(sr[2]);
            bank47_sel_in = sr[3][0];
            bank813_sel_in = sr[4][0];
            foreach (r[j]) begin
                r[j] = 1 + $urandom % 5;
                set_cd(dv[j], r[j]);
            end
            foreach (r[j]) measure(ck[j], r[j] * 2 * hp[sr[j]]);
        end
        for (int k = 0; k < 4; k++) begin
            d = (k == 0) ? 16'h0000 : 16'($urandom & $urandom);
            drv_en_in = d;
            repeat (3) @(negedge ref_clk_in);
            cmp("active ch0", d[0], div_active_out[0]);
            cmp("active ch1", d[1], div_active_out[1]);
            for (int j = 4; j < 9; j++) cmp("active pair", |d[2*j-4 +: 2], div_active_out[j]);
            for (int j = 2; j < 4; j++) cmp("active ch2/3", |d[3:2], div_active_out[j]);
            for (int j = 9; j < 11; j++) cmp("active ch14/15", |d[15:14], div_active_out[j]);
        end
        drv_en_in = '1;
        set_cd(0, 4);
        set_cd(1, 1);
        set_cd(4, 4);
        ch0_sel_in = 3'h0;
        ch1_sel_in = 3'h1;
        bank47_sel_in = 0;
        div_sync_en_in = 11'h013;
        for (int v = 0; v < 2; v++) begin
            if (v == 0) sync_pin_in = 1;
            else sync_sw_in = 1;
            probe_sel = 1;
            repeat (4) @(negedge ref_clk_in);
            n0 = rx_edges;
            repeat (30) begin
                @(negedge ref_clk_in);
                cmp("held ch0", 0, clk_out[0]);
            end
            cmp("bypass runs", 1, rx_edges > n0 + 2);
            sync_pin_in = 0;
            sync_sw_in = 0;
            probe_sel = 0;
            n0 = rx_edges;
            repeat (40) begin
                @(negedge ref_clk_in);
                cmp("aligned", clk_out[0], clk_out[4]);
                cmp("pair", clk_out[4], clk_out[5]);
            end
            cmp("released runs", 1, rx_edges > n0 + 1);
        end
        div_sync_en_in = '0;
        set_cd(0, 2);
        sd_ratio_in[19:0] = 20'h0_0003;
        sd_enable_in[0] = 1;
        measure(0, 2 * 3 * 4);
        request_resample_mode_in = OCD_REQ_MODE_RESAMPLE;
        request_sample_source_in = 2'h0;
        pin_output_enable_in = 2'h1;
        replica_source_enable_in = 11'h001;
        sd_pulse_mode_in[0] = 1;
        sysref_req_in = 1'($urandom);
        measure(16, 24);
        cmp("request sampled", sysref_req_in, sysref_req_sampled_out);
        cmp("replica drive", 1, gpio_replica_oe_out[0]);
        sd_enable_in = '0;
        sd_pulse_mode_in = '0;
        set_cd(4, 3);
        set_cd(7, 4);
        bank47_sel_in = 1;
        bank813_sel_in = 0;
        for (int z = 1; z < 4; z++) begin
            zero_delay_feedback_sel_in = 2'(z);
            measure(18, z == 1 ? 8 : z == 2 ? 18 : 16);
        end
        for (int m = 0; m < 4; m++) begin
            cmos_mode_in[1:0] = 2'(m);
            repeat (3) @(negedge ref_clk_in);
            cmp("cmos oe", m != 2, cmos_oe_out[0]);
            if (m == 3) cmp("cmos low", 0, cmos_out[0]);
        end
        conclude();
    end
endmodule // tb
